/* common/osr_defs.vh */
`ifndef OSR_DEFS_VH
`define OSR_DEFS_VH

// Register byte offsets
`define OSR_ADDR_TERM_SEL_A   8'h00
`define OSR_ADDR_TERM_SEL_B   8'h04
`define OSR_ADDR_POLARITY     8'h08
`define OSR_ADDR_FAULT_CFG    8'h0c
`define OSR_ADDR_STATUS       8'h10
`define OSR_ADDR_ID           8'h14

// Field layout
`define OSR_SEL_W             6
`define OSR_TERM1_SEL_LSB     0
`define OSR_TERM2_SEL_LSB     8
`define OSR_TERM3_SEL_LSB     16
`define OSR_TERM4_SEL_LSB     24
`define OSR_TERM5_SEL_LSB     0
`define OSR_RELAY_SEL_LSB     8
`define OSR_FCW_W             2
`define OSR_FAULT_CODE_LSB    8

// Reset values
`define OSR_SEL_RESET         6'h3f
`define OSR_POL_RESET         6'h00
`define OSR_FCW_RESET         2'h0
`define OSR_ID_VALUE          32'h0052_0001 // Identity value, arbitrary

// Fault code width settings
`define OSR_FCW_OFF           2'h0
`define OSR_FCW_3BIT          2'h1
`define OSR_FCW_4BIT          2'h2

// AXI responses
`define OSR_RESP_OKAY         2'h0
`define OSR_RESP_SLVERR       2'h2

// Selector codes
`define OSR_SEL_RUN           6'h00
`define OSR_SEL_FA1           6'h01
`define OSR_SEL_FA2           6'h02
`define OSR_SEL_OVL           6'h03
`define OSR_SEL_PIDDEV        6'h04
`define OSR_SEL_ALARM         6'h05
`define OSR_SEL_FA3           6'h06
`define OSR_SEL_OTQ           6'h07
`define OSR_SEL_PWRLOSS       6'h08
`define OSR_SEL_UNDERV        6'h09
`define OSR_SEL_TRQLIM        6'h0a
`define OSR_SEL_RUNTIME       6'h0b
`define OSR_SEL_ONTIME        6'h0c
`define OSR_SEL_THERMAL       6'h0d
`define OSR_SEL_BRKREL        6'h13
`define OSR_SEL_BRKERR        6'h14
`define OSR_SEL_ZEROF         6'h15
`define OSR_SEL_SPDDEV        6'h16
`define OSR_SEL_POSDONE       6'h17
`define OSR_SEL_FA4           6'h18
`define OSR_SEL_FA5           6'h19
`define OSR_SEL_OVL2          6'h1a
`define OSR_SEL_VOPEN         6'h1b
`define OSR_SEL_IOPEN         6'h1c
`define OSR_SEL_V2OPEN        6'h1d
`define OSR_SEL_PIDFB         6'h1f
`define OSR_SEL_COMM          6'h20
`define OSR_SEL_LOG_FIRST     6'h21
`define OSR_SEL_LOG_LAST      6'h26
`define OSR_SEL_CAPLIFE       6'h27
`define OSR_SEL_FANSLOW       6'h28
`define OSR_SEL_STARTC        6'h29
`define OSR_SEL_HSHOT         6'h2a
`define OSR_SEL_LOWCUR        6'h2b
`define OSR_SEL_USEQ_FIRST    6'h2c
`define OSR_SEL_USEQ_LAST     6'h31
`define OSR_SEL_READY         6'h32
`define OSR_SEL_FWD           6'h33
`define OSR_SEL_REV           6'h34
`define OSR_SEL_MAJOR         6'h35
`define OSR_SEL_WCV           6'h36
`define OSR_SEL_WCI           6'h37
`define OSR_SEL_WCV2          6'h38

`endif

/* verilog/osr_source_mux.v */
`timescale 1ns/10ps
`default_nettype none
`include "osr_defs.vh"

module osr_source_mux
(
  // Selector
  input  wire [5:0]  sel,
  // Condition vector, index by selector code
  input  wire [63:0] cond,
  // Routed condition
  output wire        active
);

  assign active = cond[sel];

endmodule // osr_source_mux

`default_nettype wire

/* verilog/osr_output_stage.v */
`timescale 1ns/10ps
`default_nettype none
`include "osr_defs.vh"

module osr_output_stage
(
  // Clock and reset
  input  wire aclk,
  input  wire aresetn,
  // Condition and polarity
  input  wire active,
  input  wire normally_closed,
  // Switch closed
  output reg  closed
);

  always @(posedge aclk)
  begin
    if (!aresetn)
      closed <= 1'b0;
    else
      closed <= active ^ normally_closed;
  end

endmodule // osr_output_stage

`default_nettype wire

/* verilog/osr_output_signal_router.v */
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "osr_defs.vh"

module osr_output_signal_router
(
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Drive conditions
  input  wire        running,
  input  wire        dc_braking,
  input  wire        const_speed_reached,
  input  wire        set_freq_overreached,
  input  wire        set_freq_reached,
  input  wire        set_freq_overreached_b,
  input  wire        set_freq_reached_b,
  input  wire        overload_notice,
  input  wire        overload_notice_b,
  input  wire        pid_deviation,
  input  wire        alarm_out,
  input  wire        over_torque,
  input  wire        power_loss_flag,
  input  wire        undervolt_flag,
  input  wire        torque_limited,
  input  wire        run_time_over,
  input  wire        power_on_time_over,
  input  wire        thermal_alarm,
  input  wire        brake_release,
  input  wire        brake_error,
  input  wire        zero_freq_detect,
  input  wire        speed_deviation_max,
  input  wire        positioning_done,
  input  wire        volt_input_open,
  input  wire        current_input_open,
  input  wire        volt2_input_open,
  input  wire        pid_feedback_cmp,
  input  wire        comm_line_lost,
  input  wire [5:0]  logic_result,
  input  wire        capacitor_life_warn,
  input  wire        fan_slow_warn,
  input  wire        start_contact,
  input  wire        heatsink_hot_warn,
  input  wire        low_current_ind,
  input  wire [5:0]  user_seq_out,
  input  wire        drive_ready,
  input  wire        forward_rotation,
  input  wire        reverse_rotation,
  input  wire        major_failure,
  input  wire        window_cmp_v,
  input  wire        window_cmp_i,
  input  wire        window_cmp_v2,
  // Fault code
  input  wire [3:0]  fault_code,
  // Outputs, high means switch closed
  output wire [4:0]  term_closed,
  output wire        relay_closed
);

  // Settings
  reg  [5:0]  term1_source_sel;
  reg  [5:0]  term2_source_sel;
  reg  [5:0]  term3_source_sel;
  reg  [5:0]  term4_source_sel;
  reg  [5:0]  term5_source_sel;
  reg  [5:0]  relay_source_sel;
  reg  [4:0]  term_polarity;
  reg         relay_polarity;
  reg  [1:0]  fault_code_width;

  // Bus state
  reg         aw_held;
  reg  [7:0]  aw_addr;
  reg         w_held;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;

  // Condition vector
  reg  [63:0] cond;
  wire [5:0]  routed;
  reg  [5:0]  term_active;
  wire [5:0]  normally_closed;
  wire [5:0]  closed;

  integer     i;

  // Merge a 6-bit field under byte strobe
  function [5:0] merge_field;
    input [5:0] old;
    input [7:0] lane;
    input       en;
    begin
      merge_field = en ? lane[5:0] : old;
    end
  endfunction

  function is_mapped;
    input [7:0] a;
    begin
      if (a == `OSR_ADDR_TERM_SEL_A)
        is_mapped = 1'b1;
      else if (a == `OSR_ADDR_TERM_SEL_B)
        is_mapped = 1'b1;
      else if (a == `OSR_ADDR_POLARITY)
        is_mapped = 1'b1;
      else if (a == `OSR_ADDR_FAULT_CFG)
        is_mapped = 1'b1;
      else if (a == `OSR_ADDR_STATUS)
        is_mapped = 1'b1;
      else if (a == `OSR_ADDR_ID)
        is_mapped = 1'b1;
      else
        is_mapped = 1'b0;
    end
  endfunction

  // Write channel: hold address and data until both arrive
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;

  wire do_write = aw_held && w_held && !s_axi_bvalid;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `OSR_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= is_mapped(aw_addr) ? `OSR_RESP_OKAY : `OSR_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Settings registers
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      term1_source_sel <= `OSR_SEL_RESET;
      term2_source_sel <= `OSR_SEL_RESET;
      term3_source_sel <= `OSR_SEL_RESET;
      term4_source_sel <= `OSR_SEL_RESET;
      term5_source_sel <= `OSR_SEL_RESET;
      relay_source_sel <= `OSR_SEL_RESET;
      term_polarity    <= 5'h00;
      relay_polarity   <= 1'b0;
      fault_code_width <= `OSR_FCW_RESET;
    end
    else if (do_write)
    begin
      if (aw_addr == `OSR_ADDR_TERM_SEL_A)
      begin
        term1_source_sel <= merge_field(term1_source_sel, w_data[7:0], w_strb[0]);
        term2_source_sel <= merge_field(term2_source_sel, w_data[15:8], w_strb[1]);
        term3_source_sel <= merge_field(term3_source_sel, w_data[23:16], w_strb[2]);
        term4_source_sel <= merge_field(term4_source_sel, w_data[31:24], w_strb[3]);
      end
      else if (aw_addr == `OSR_ADDR_TERM_SEL_B)
      begin
        term5_source_sel <= merge_field(term5_source_sel, w_data[7:0], w_strb[0]);
        relay_source_sel <= merge_field(relay_source_sel, w_data[15:8], w_strb[1]);
      end
      else if (aw_addr == `OSR_ADDR_POLARITY)
      begin
        if (w_strb[0])
        begin
          term_polarity  <= w_data[4:0];
          relay_polarity <= w_data[5];
        end
      end
      else if (aw_addr == `OSR_ADDR_FAULT_CFG)
      begin
        if (w_strb[0])
          fault_code_width <= w_data[1:0];
      end
    end
  end

  // Read channel
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `OSR_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `OSR_RESP_OKAY;
      if (s_axi_araddr == `OSR_ADDR_TERM_SEL_A)
        s_axi_rdata <= {2'h0, term4_source_sel, 2'h0, term3_source_sel,
                        2'h0, term2_source_sel, 2'h0, term1_source_sel};
      else if (s_axi_araddr == `OSR_ADDR_TERM_SEL_B)
        s_axi_rdata <= {16'h0000, 2'h0, relay_source_sel, 2'h0, term5_source_sel};
      else if (s_axi_araddr == `OSR_ADDR_POLARITY)
        s_axi_rdata <= {26'h0, relay_polarity, term_polarity};
      else if (s_axi_araddr == `OSR_ADDR_FAULT_CFG)
        s_axi_rdata <= {20'h0, fault_code, 6'h0, fault_code_width};
      else if (s_axi_araddr == `OSR_ADDR_STATUS)
        s_axi_rdata <= {26'h0, closed};
      else if (s_axi_araddr == `OSR_ADDR_ID)
        s_axi_rdata <= `OSR_ID_VALUE;
      else
      begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `OSR_RESP_SLVERR;
      end
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Condition table indexed by selector code
  always @*
  begin
    cond = 64'h0;
    cond[`OSR_SEL_RUN]     = running || dc_braking;
    cond[`OSR_SEL_FA1]     = const_speed_reached;
    cond[`OSR_SEL_FA2]     = set_freq_overreached;
    cond[`OSR_SEL_FA3]     = set_freq_reached;
    cond[`OSR_SEL_FA4]     = set_freq_overreached_b;
    cond[`OSR_SEL_FA5]     = set_freq_reached_b;
    cond[`OSR_SEL_OVL]     = overload_notice;
    cond[`OSR_SEL_ALARM]   = alarm_out;
    cond[`OSR_SEL_OTQ]     = over_torque;
    cond[`OSR_SEL_PWRLOSS] = power_loss_flag;
    cond[`OSR_SEL_UNDERV]  = undervolt_flag;
    cond[`OSR_SEL_TRQLIM]  = torque_limited;
    cond[`OSR_SEL_THERMAL] = thermal_alarm;
    cond[`OSR_SEL_RUNTIME] = run_time_over;
    cond[`OSR_SEL_ONTIME]  = power_on_time_over;
    cond[`OSR_SEL_ZEROF]   = zero_freq_detect;
    cond[`OSR_SEL_BRKREL]  = brake_release;
    cond[`OSR_SEL_BRKERR]  = brake_error;
    cond[`OSR_SEL_SPDDEV]  = speed_deviation_max;
    cond[`OSR_SEL_POSDONE] = positioning_done;
    cond[`OSR_SEL_VOPEN]   = volt_input_open;
    cond[`OSR_SEL_IOPEN]   = current_input_open;
    cond[`OSR_SEL_V2OPEN]  = volt2_input_open;
    cond[`OSR_SEL_COMM]    = comm_line_lost;
    for (i = 0; i < 6; i = i + 1)
    begin
      cond[`OSR_SEL_LOG_FIRST + i]  = logic_result[i];
      cond[`OSR_SEL_USEQ_FIRST + i] = user_seq_out[i];
    end
    cond[`OSR_SEL_CAPLIFE] = capacitor_life_warn;
    cond[`OSR_SEL_FANSLOW] = fan_slow_warn;
    cond[`OSR_SEL_HSHOT]   = heatsink_hot_warn;
    cond[`OSR_SEL_LOWCUR]  = low_current_ind;
    cond[`OSR_SEL_STARTC]  = start_contact;
    cond[`OSR_SEL_READY]   = drive_ready;
    cond[`OSR_SEL_FWD]     = forward_rotation;
    cond[`OSR_SEL_REV]     = reverse_rotation;
    cond[`OSR_SEL_MAJOR]   = major_failure;
    cond[`OSR_SEL_PIDDEV]  = pid_deviation;
    cond[`OSR_SEL_OVL2]    = overload_notice_b;
    cond[`OSR_SEL_PIDFB]   = pid_feedback_cmp;
    cond[`OSR_SEL_WCV]     = window_cmp_v;
    cond[`OSR_SEL_WCI]     = window_cmp_i;
    cond[`OSR_SEL_WCV2]    = window_cmp_v2;
  end

  osr_source_mux u_mux1 (.sel(term1_source_sel), .cond(cond), .active(routed[0]));
  osr_source_mux u_mux2 (.sel(term2_source_sel), .cond(cond), .active(routed[1]));
  osr_source_mux u_mux3 (.sel(term3_source_sel), .cond(cond), .active(routed[2]));
  osr_source_mux u_mux4 (.sel(term4_source_sel), .cond(cond), .active(routed[3]));
  osr_source_mux u_mux5 (.sel(term5_source_sel), .cond(cond), .active(routed[4]));
  osr_source_mux u_mux6 (.sel(relay_source_sel), .cond(cond), .active(routed[5]));

  // Fault code takeover of the low terminals
  always @*
  begin
    term_active = routed;
    if (fault_code_width == `OSR_FCW_3BIT)
      term_active[3:0] = {1'b0, fault_code[2:0]};
    else if (fault_code_width == `OSR_FCW_4BIT)
      term_active[3:0] = fault_code[3:0];
  end

  assign normally_closed = {relay_polarity, term_polarity};

  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1)
    begin : g_out
      osr_output_stage u_stage
      (
        .aclk            (aclk),
        .aresetn         (aresetn),
        .active          (term_active[g]),
        .normally_closed (normally_closed[g]),
        .closed          (closed[g])
      );
    end
  endgenerate

  assign term_closed  = closed[4:0];
  assign relay_closed = closed[5];

endmodule // osr_output_signal_router

`default_nettype wire

/* test/osr_checker.sv */
`timescale 1ns/10ps
`default_nettype none
`include "osr_defs.vh"

module osr_checker
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Switch states
  input wire logic [4:0]  term_closed,
  input wire logic        relay_closed
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence

  property p_reset_open;
    $rose(aresetn) |-> term_closed == 5'h00 && !relay_closed;
  endproperty
  a_reset_open: assert property (p_reset_open) else $error("switch closed after reset");
  property p_aw_refuse;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_aw_refuse: assert property (p_aw_refuse) else $error("write taken during response");
  property p_ar_refuse;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_refuse: assert property (p_ar_refuse) else $error("read taken during response");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read response dropped");
  property p_wr_answer;
    s_wr_take |=> ##1 s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
  property p_rd_answer;
    s_rd_take |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_rd_unmapped;
    s_rd_take and s_axi_araddr > 8'h14 |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not refused");
  property p_rd_id;
    s_rd_take and s_axi_araddr == 8'h14 |=> s_axi_rresp == 2'h0
      && s_axi_rdata == `OSR_ID_VALUE;
  endproperty
  a_rd_id: assert property (p_rd_id) else $error("identity read wrong");
endmodule // osr_checker

`default_nettype wire

/* test/osr_load_model.sv */
`timescale 1ns/10ps
`default_nettype none

module osr_load_model
(
  // Clock
  input  wire logic       aclk,
  // Switch states and pace
  input  wire logic [4:0] term_closed,
  input  wire logic       relay_closed,
  input  wire logic       slow,
  // Load energised
  output var  logic [5:0] lamp
);
  logic [5:0] stage [3];

  // Slow loads lag the contact by four cycles
  always @(posedge aclk)
  begin
    stage[0] <= {relay_closed, term_closed};
    stage[1] <= stage[0];
    stage[2] <= stage[1];
    lamp     <= slow ? stage[2] : {relay_closed, term_closed};
  end
endmodule // osr_load_model

`default_nettype wire

/* test/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "osr_defs.vh"

module tb_top;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, slow;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata;
  logic [63:0] cv;
  logic [3:0]  fc, wstrb;
  wire         awready, wready, bvalid, arready, rvalid, relay_closed;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [4:0]  term_closed;
  wire  [5:0]  lamp;
  int          failures, cmp_count;
  // Codes with a routed condition
  localparam logic [63:0] DEFD = 64'h01ff_ffff_bff8_3fff;
  // Rows: polarity, condition, expected outputs
  logic [12:0] rows [5] = '{{6'h00, 1'b0, 6'h00}, {6'h00, 1'b1, 6'h3f},
    {6'h3f, 1'b0, 6'h3f}, {6'h3f, 1'b1, 6'h00}, {6'h15, 1'b1, 6'h2a}};

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  osr_output_signal_router dut
  (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .running(cv[0]), .dc_braking(cv[14]), .const_speed_reached(cv[1]),
    .set_freq_overreached(cv[2]), .set_freq_reached(cv[6]), .set_freq_overreached_b(cv[24]),
    .set_freq_reached_b(cv[25]), .overload_notice(cv[3]), .overload_notice_b(cv[26]),
    .pid_deviation(cv[4]), .alarm_out(cv[5]), .over_torque(cv[7]), .power_loss_flag(cv[8]),
    .undervolt_flag(cv[9]), .torque_limited(cv[10]), .run_time_over(cv[11]),
    .power_on_time_over(cv[12]), .thermal_alarm(cv[13]), .brake_release(cv[19]),
    .brake_error(cv[20]), .zero_freq_detect(cv[21]), .speed_deviation_max(cv[22]),
    .positioning_done(cv[23]), .volt_input_open(cv[27]), .current_input_open(cv[28]),
    .volt2_input_open(cv[29]), .pid_feedback_cmp(cv[31]), .comm_line_lost(cv[32]),
    .logic_result(cv[38:33]), .capacitor_life_warn(cv[39]), .fan_slow_warn(cv[40]),
    .start_contact(cv[41]), .heatsink_hot_warn(cv[42]), .low_current_ind(cv[43]),
    .user_seq_out(cv[49:44]), .drive_ready(cv[50]), .forward_rotation(cv[51]),
    .reverse_rotation(cv[52]), .major_failure(cv[53]), .window_cmp_v(cv[54]),
    .window_cmp_i(cv[55]), .window_cmp_v2(cv[56]), .fault_code(fc),
    .term_closed(term_closed), .relay_closed(relay_closed)
  );

  osr_load_model u_load
  (
    .aclk(aclk), .term_closed(term_closed), .relay_closed(relay_closed), .slow(slow),
    .lamp(lamp)
  );

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk_out(input string what, input logic [5:0] e, input logic [5:0] g);
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chk_bus(input string what, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic timeout;
    failures++;
    $display("CHECK FAILED handshake expected answer seen none");
    give_verdict();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    for (int n = 0; n < 50 && !tb; n++)
    begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid & bready;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (!tb) timeout();
    chk_bus("bresp", {30'h0, er}, {30'h0, r});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    tr = 1'b0;
    for (int n = 0; n < 50 && !tr; n++)
    begin
      @(negedge aclk);
      ta = arvalid & arready;
      tr = rvalid & rready;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (!tr) timeout();
    chk_bus("rdata", ed, d);
    chk_bus("rresp", {30'h0, er}, {30'h0, r});
  endtask

  task automatic sel_all(input logic [5:0] c);
    wr(`OSR_ADDR_TERM_SEL_A, {4{2'b00, c}}, `OSR_RESP_OKAY);
    wr(`OSR_ADDR_TERM_SEL_B, {16'h0, {2{2'b00, c}}}, `OSR_RESP_OKAY);
  endtask

  task automatic look(input logic [5:0] e);
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk_out("outputs", e, {relay_closed, term_closed});
    if (!slow) chk_out("lamp", e, lamp);
    @(posedge aclk);
  endtask

  initial
  begin
    failures = 0;
    cmp_count = 0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, slow} = 7'h00;
    {awaddr, araddr, wdata, cv, fc} = '0;
    wstrb = 4'hf;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    look(6'h00);
    rd(`OSR_ADDR_TERM_SEL_A, 32'h3f3f_3f3f, `OSR_RESP_OKAY);
    rd(`OSR_ADDR_TERM_SEL_B, 32'h0000_3f3f, `OSR_RESP_OKAY);
    rd(`OSR_ADDR_POLARITY, 32'h0, `OSR_RESP_OKAY);
    rd(`OSR_ADDR_FAULT_CFG, 32'h0, `OSR_RESP_OKAY);
    rd(`OSR_ADDR_ID, `OSR_ID_VALUE, `OSR_RESP_OKAY);
    rd(8'h18, 32'h0, `OSR_RESP_SLVERR);
    wr(8'h18, 32'hffff_ffff, `OSR_RESP_SLVERR);
    wr(`OSR_ADDR_ID, 32'h0, `OSR_RESP_OKAY);
    rd(`OSR_ADDR_ID, `OSR_ID_VALUE, `OSR_RESP_OKAY);
    wstrb <= 4'h2;
    wr(`OSR_ADDR_TERM_SEL_A, 32'h2a2a_052a, `OSR_RESP_OKAY);
    wstrb <= 4'hf;
    rd(`OSR_ADDR_TERM_SEL_A, 32'h3f3f_053f, `OSR_RESP_OKAY);
    $display("test reset and map done");
    sel_all(`OSR_SEL_ALARM);
    foreach (rows[i])
    begin
      wr(`OSR_ADDR_POLARITY, {26'h0, rows[i][12:7]}, `OSR_RESP_OKAY);
      cv <= {58'h0, rows[i][6], 5'h0};
      look(rows[i][5:0]);
    end
    $display("test polarity table done");
    wr(`OSR_ADDR_POLARITY, 32'h0, `OSR_RESP_OKAY);
    slow <= 1'b1;
    for (int c = 0; c < 64; c++)
    begin
      sel_all(c[5:0]);
      cv <= 64'h1 << c;
      look({6{DEFD[c]}});
      cv <= ~(64'h1 << c);
      look(c == 0 ? 6'h3f : 6'h00);
    end
    slow <= 1'b0;
    $display("test selector sweep done");
    sel_all(`OSR_SEL_ALARM);
    cv <= 64'h20;
    fc <= 4'ha;
    wr(`OSR_ADDR_FAULT_CFG, {30'h0, `OSR_FCW_3BIT}, `OSR_RESP_OKAY);
    look(6'h32);
    rd(`OSR_ADDR_FAULT_CFG, 32'h0000_0a01, `OSR_RESP_OKAY);
    rd(`OSR_ADDR_STATUS, 32'h0000_0032, `OSR_RESP_OKAY);
    fc <= 4'h5;
    wr(`OSR_ADDR_FAULT_CFG, {30'h0, `OSR_FCW_4BIT}, `OSR_RESP_OKAY);
    look(6'h35);
    wr(`OSR_ADDR_FAULT_CFG, 32'h3, `OSR_RESP_OKAY);
    look(6'h3f);
    $display("test fault code done");
    cv <= 64'h0;
    wr(`OSR_ADDR_POLARITY, 32'h3f, `OSR_RESP_OKAY);
    look(6'h3f);
    aresetn <= 1'b0;
    look(6'h00);
    aresetn <= 1'b1;
    look(6'h00);
    rd(`OSR_ADDR_POLARITY, 32'h0, `OSR_RESP_OKAY);
    $display("test second reset done");
    give_verdict();
  end
endmodule // tb_top

bind osr_output_signal_router osr_checker u_chk
(
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .term_closed, .relay_closed
);

`default_nettype wire
